// ### core/icd_pkg.sv
// Functional notes
// R1: depth code 00/01/10 = 1/2/4 bpp, 11 reserved
// R2: 60h loads one byte into depth select
// R3: host sets char width 7h, pan zero first
// R4: 40h loads eight bytes into 8000h-8007h
// R5: 53h, no parameters, enters standby
// R6: 59h display on, 58h off, one attribute byte
// R7: 44h loads ten bytes into 800Bh-8014h
// R8: 4Ch-4Fh set cursor direction from low bits
// R9: 5Bh loads one byte into overlay format
// R10: 5Ch loads glyph base, low byte first
// R11: 5Ah loads one byte into pixel pan
// R12: generic bus decode of a0, wr_n, rd_n
// R13: 6800 bus decode of a0, rw with e high
// R14: 68000 bus decode of a0, rw with lds_n low
// R15: first init byte keeps bits 5,3,2,0 only
// R16: second init byte keeps bit 7, bits 3-0
// R17: third byte low nibble; four to eight whole
// R18: control byte then fixed count of parameters
// R19: cursor read returns low then high byte
// R20: memory access uses cursor, then increments it
// R21: unknown commands, surplus parameters are ignored
package icd_pkg;
  localparam int CLK_MHZ = 200;
  localparam int SETUP_NS = 20;
  localparam int STROBE_NS = 60;
  localparam int HOLD_NS = 20;
  localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_CYC = (HOLD_NS * CLK_MHZ + 999) / 1000;

  localparam logic [1:0] BUS_GENERIC = 2'h0;
  localparam logic [1:0] BUS_M6800 = 2'h1;
  localparam logic [1:0] BUS_M68K = 2'h2;

  localparam logic [7:0] CMD_SYSTEM = 8'h40;
  localparam logic [7:0] CMD_STANDBY = 8'h53;
  localparam logic [7:0] CMD_DISP_OFF = 8'h58;
  localparam logic [7:0] CMD_DISP_ON = 8'h59;
  localparam logic [7:0] CMD_SCREEN = 8'h44;
  localparam logic [7:0] CMD_CURSOR_SHAPE = 8'h5d;
  localparam logic [7:0] CMD_DIR_LO = 8'h4c;
  localparam logic [7:0] CMD_DIR_HI = 8'h4f;
  localparam logic [7:0] CMD_OVERLAY = 8'h5b;
  localparam logic [7:0] CMD_GLYPH = 8'h5c;
  localparam logic [7:0] CMD_PAN = 8'h5a;
  localparam logic [7:0] CMD_CURSOR_WR = 8'h46;
  localparam logic [7:0] CMD_CURSOR_RD = 8'h47;
  localparam logic [7:0] CMD_DEPTH = 8'h60;
  localparam logic [7:0] CMD_MEM_WR = 8'h42;
  localparam logic [7:0] CMD_MEM_RD = 8'h43;

  // register array index = address - REG_BASE_ADDR
  localparam logic [15:0] REG_BASE_ADDR = 16'h8000;
  localparam logic [15:0] PIXEL_DEPTH_SELECT_ADDR = 16'h8020;
  localparam int REG_CNT = 33;
  localparam logic [5:0] IDX_SYS = 6'h00;
  localparam logic [5:0] IDX_STANDBY = 6'h08;
  localparam logic [5:0] IDX_DISP = 6'h0a;
  localparam logic [5:0] IDX_SCREEN = 6'h0b;
  localparam logic [5:0] IDX_SHAPE = 6'h15;
  localparam logic [5:0] IDX_DIR = 6'h17;
  localparam logic [5:0] IDX_OVERLAY = 6'h18;
  localparam logic [5:0] IDX_GLYPH = 6'h19;
  localparam logic [5:0] IDX_PAN = 6'h1b;
  localparam logic [5:0] IDX_CURSOR_WR = 6'h1c;
  localparam logic [5:0] IDX_CURSOR_RD = 6'h1e;
  localparam logic [5:0] IDX_DEPTH = 6'h20;
  localparam logic [7:0] REG_RESET = 8'h00;

  localparam logic [3:0] CNT_NONE = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] CNT_TWO = 4'h2;
  localparam logic [3:0] CNT_SYS = 4'h8;
  localparam logic [3:0] CNT_SCREEN = 4'ha;

  localparam logic [7:0] MASK_SYS_P1 = 8'h2d;
  localparam logic [7:0] MASK_SYS_P2 = 8'h8f;
  localparam logic [7:0] MASK_SYS_P3 = 8'h0f;
  localparam logic [7:0] MASK_DEPTH = 8'h03;
  localparam logic [7:0] MASK_PAN = 8'h07;
  localparam logic [7:0] MASK_FULL = 8'hff;

  localparam logic [1:0] DEPTH_1BPP = 2'h0;
  localparam logic [1:0] DEPTH_2BPP = 2'h1;
  localparam logic [1:0] DEPTH_4BPP = 2'h2;
  localparam logic [2:0] BPP_ONE = 3'h1;
  localparam logic [2:0] BPP_TWO = 3'h2;
  localparam logic [2:0] BPP_FOUR = 3'h4;
  localparam logic [2:0] BPP_RESERVED = 3'h0;

  localparam logic [7:0] HOST_CMD_OFS = 8'h00;
  localparam logic [7:0] HOST_STAT_OFS = 8'h04;
  localparam int CMD_A0_BIT = 8;
  localparam int CMD_RD_BIT = 9;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DATA_LSB = 8;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [7:0] BYTE_IDLE = 8'h00;

  typedef enum logic [1:0] {
    OP_NONE = 2'h0,
    OP_CMD = 2'h1,
    OP_PWR = 2'h3,
    OP_PRD = 2'h2
  } op_type;

  typedef enum logic [2:0] {
    K_NONE = 3'h0,
    K_LOAD = 3'h1,
    K_CURSOR_W = 3'h2,
    K_CURSOR_R = 3'h3,
    K_MEM_W = 3'h4,
    K_MEM_R = 3'h5
  } kind_type;

  typedef struct packed {
    kind_type kind;
    logic [5:0] base;
    logic [3:0] cnt;
  } info_type;

  typedef struct packed {
    logic a0;
    logic wr_n;
    logic rd_n;
    logic rw;
    logic e;
    logic lds_n;
    logic [7:0] d;
  } pin_type;

  // parameter group of each control byte
  function automatic info_type cmd_info(input logic [7:0] c);
    info_type i;
    i = '{K_NONE, IDX_SYS, CNT_NONE};
    if (c == CMD_SYSTEM) i = '{K_LOAD, IDX_SYS, CNT_SYS};
    else if (c == CMD_DISP_ON || c == CMD_DISP_OFF)
      i = '{K_LOAD, IDX_DISP, CNT_ONE};
    else if (c == CMD_SCREEN) i = '{K_LOAD, IDX_SCREEN, CNT_SCREEN};
    else if (c == CMD_CURSOR_SHAPE) i = '{K_LOAD, IDX_SHAPE, CNT_TWO};
    else if (c == CMD_OVERLAY) i = '{K_LOAD, IDX_OVERLAY, CNT_ONE};
    else if (c == CMD_GLYPH) i = '{K_LOAD, IDX_GLYPH, CNT_TWO};
    else if (c == CMD_PAN) i = '{K_LOAD, IDX_PAN, CNT_ONE};
    else if (c == CMD_CURSOR_WR) i = '{K_CURSOR_W, IDX_CURSOR_WR, CNT_TWO};
    else if (c == CMD_CURSOR_RD) i = '{K_CURSOR_R, IDX_CURSOR_RD, CNT_TWO};
    else if (c == CMD_DEPTH) i = '{K_LOAD, IDX_DEPTH, CNT_ONE};
    else if (c == CMD_MEM_WR) i = '{K_MEM_W, IDX_SYS, CNT_NONE};
    else if (c == CMD_MEM_RD) i = '{K_MEM_R, IDX_SYS, CNT_NONE};
    return i;
  endfunction
endpackage

// ### core/icd_if.sv
`timescale 1ns/10ps
`default_nettype none
interface icd_if;
  logic a0;
  logic wr_n;
  logic rd_n;
  logic rw;
  logic e;
  logic lds_n;
  logic [7:0] hd_o;
  logic hd_oe;
  logic [7:0] dd_o;
  logic dd_oe;
  logic [7:0] d;
  // shared data wire; pulled high when nobody drives
  assign d = hd_oe ? hd_o : (dd_oe ? dd_o : 8'hff);
  modport host_mp(output a0, wr_n, rd_n, rw, e, lds_n, hd_o, hd_oe,
                  input d);
  modport dev_mp(input a0, wr_n, rd_n, rw, e, lds_n, d,
                 output dd_o, dd_oe);
endinterface
`default_nettype wire

// ### core/icd_device.sv
`timescale 1ns/10ps
`default_nettype none
module icd_device
  import icd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [1:0] bus_mode,
  icd_if.dev_mp bus,
  input wire logic [7:0] mem_rdata,
  input wire logic [5:0] cfg_sel,
  output logic [7:0] cfg_q,
  output logic [2:0] bpp,
  output logic display_on,
  output logic standby,
  output logic [1:0] cursor_dir,
  output logic [15:0] cursor_addr,
  output logic mem_we,
  output logic [15:0] mem_waddr,
  output logic [7:0] mem_wdata
);
  typedef struct packed {
    pin_type s1;
    pin_type s2;
    pin_type s3;
    pin_type agreed;
    op_type op_prev;
    logic [7:0] cmd;
    logic [3:0] pidx;
    logic [REG_CNT-1:0][7:0] regs;
    logic [15:0] cursor;
    logic disp_on;
    logic standby;
    logic [2:0] bpp;
    logic [7:0] dd_o;
    logic dd_oe;
    logic mem_we;
    logic [15:0] mem_waddr;
    logic [7:0] mem_wdata;
    logic [7:0] cfg_q;
  } st_type;

  st_type st_r;
  st_type st_nxt;
  pin_type pins_now;

  function automatic op_type decode(input logic [1:0] m, input pin_type p);
    op_type o;
    o = OP_NONE;
    if (m == BUS_GENERIC) begin
      // R12 generic strobes
      if (p.a0 && !p.wr_n && p.rd_n) o = OP_CMD;
      else if (p.a0 && !p.rd_n && p.wr_n) o = OP_PRD;
      else if (!p.a0 && !p.wr_n && p.rd_n) o = OP_PWR;
    end else if ((m == BUS_M6800 && p.e) || (m == BUS_M68K && !p.lds_n)) begin
      // R13 R14 shared a0 and rw decode
      if (p.a0) o = p.rw ? OP_PRD : OP_CMD;
      else if (!p.rw) o = OP_PWR;
    end
    return o;
  endfunction

  // R15 R16 R17 unused bits of init bytes forced to zero
  function automatic logic [7:0] mask_of(input logic [7:0] c,
                                         input logic [3:0] n);
    logic [7:0] m;
    m = MASK_FULL;
    if (c == CMD_SYSTEM && n == 4'h0) m = MASK_SYS_P1;
    else if (c == CMD_SYSTEM && n == 4'h1) m = MASK_SYS_P2;
    else if (c == CMD_SYSTEM && n == 4'h2) m = MASK_SYS_P3;
    else if (c == CMD_DEPTH) m = MASK_DEPTH;
    else if (c == CMD_PAN) m = MASK_PAN;
    return m;
  endfunction

  assign pins_now = '{bus.a0, bus.wr_n, bus.rd_n, bus.rw, bus.e, bus.lds_n,
                      bus.d};

  always_comb begin
    info_type ci;
    op_type op;
    logic [5:0] idx;
    ci = cmd_info(st_r.cmd);
    op = decode(bus_mode, st_r.agreed);
    idx = ci.base + {2'h0, st_r.pidx};
    st_nxt = st_r;
    st_nxt.s1 = pins_now;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    // pins count only once two later stages agree
    if (st_r.s2 == st_r.s3) st_nxt.agreed = st_r.s3;
    st_nxt.op_prev = op;
    st_nxt.mem_we = 1'b0;
    st_nxt.cfg_q = (cfg_sel < 6'(REG_CNT)) ? st_r.regs[cfg_sel] : BYTE_IDLE;
    // R1 depth code to bits per pixel
    unique case (st_r.regs[IDX_DEPTH][1:0])
      DEPTH_1BPP: st_nxt.bpp = BPP_ONE;
      DEPTH_2BPP: st_nxt.bpp = BPP_TWO;
      DEPTH_4BPP: st_nxt.bpp = BPP_FOUR;
      default: st_nxt.bpp = BPP_RESERVED;
    endcase
    if (op != OP_PRD) st_nxt.dd_oe = 1'b0;
    // act once per strobe, on its leading edge
    if (op != st_r.op_prev) begin
      unique case (op)
        OP_NONE: ;
        OP_CMD: begin
          // R18 control byte opens a new parameter run
          st_nxt.cmd = st_r.agreed.d;
          st_nxt.pidx = 4'h0;
          // R5 standby on power-save byte
          if (st_r.agreed.d == CMD_STANDBY) st_nxt.standby = 1'b1;
          if (st_r.agreed.d == CMD_SYSTEM || st_r.agreed.d == CMD_DISP_ON)
            st_nxt.standby = 1'b0;
          // R6 on/off from the control byte itself
          if (st_r.agreed.d == CMD_DISP_ON) st_nxt.disp_on = 1'b1;
          if (st_r.agreed.d == CMD_DISP_OFF) st_nxt.disp_on = 1'b0;
          // R8 direction from low two bits
          if (st_r.agreed.d >= CMD_DIR_LO && st_r.agreed.d <= CMD_DIR_HI)
            st_nxt.regs[IDX_DIR] = {6'h00, st_r.agreed.d[1:0]};
        end
        OP_PWR: begin
          // R20 memory write at cursor, then step
          if (ci.kind == K_MEM_W) begin
            st_nxt.mem_we = 1'b1;
            st_nxt.mem_waddr = st_r.cursor;
            st_nxt.mem_wdata = st_r.agreed.d;
            st_nxt.cursor = st_r.cursor + 16'h0001;
          // R21 surplus bytes and unknown commands dropped
          end else if ((ci.kind == K_LOAD || ci.kind == K_CURSOR_W) &&
                       st_r.pidx < ci.cnt) begin
            // R2 R4 R6 R7 R9 R10 R11 consecutive group fill
            st_nxt.regs[idx] = st_r.agreed.d & mask_of(st_r.cmd, st_r.pidx);
            st_nxt.pidx = st_r.pidx + 4'h1;
            if (ci.kind == K_CURSOR_W) begin
              if (st_r.pidx == 4'h0) st_nxt.cursor[7:0] = st_r.agreed.d;
              else st_nxt.cursor[15:8] = st_r.agreed.d;
            end
          end
        end
        OP_PRD: begin
          st_nxt.dd_oe = 1'b1;
          st_nxt.dd_o = BYTE_IDLE;
          // R19 cursor low byte, then high byte
          if (ci.kind == K_CURSOR_R && st_r.pidx < ci.cnt) begin
            st_nxt.dd_o = (st_r.pidx == 4'h0) ? st_r.cursor[7:0]
                                              : st_r.cursor[15:8];
            st_nxt.pidx = st_r.pidx + 4'h1;
          // R20 memory read at cursor, then step
          end else if (ci.kind == K_MEM_R) begin
            st_nxt.dd_o = mem_rdata;
            st_nxt.cursor = st_r.cursor + 16'h0001;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r <= '0;
      // idle pin levels so no strobe is seen out of reset
      st_r.s1 <= '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, BYTE_IDLE};
      st_r.s2 <= '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, BYTE_IDLE};
      st_r.s3 <= '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, BYTE_IDLE};
      st_r.agreed <= '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, BYTE_IDLE};
      st_r.bpp <= BPP_ONE;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign bus.dd_o = st_r.dd_o;
  assign bus.dd_oe = st_r.dd_oe;
  assign cfg_q = st_r.cfg_q;
  assign bpp = st_r.bpp;
  assign display_on = st_r.disp_on;
  assign standby = st_r.standby;
  assign cursor_dir = st_r.regs[IDX_DIR][1:0];
  assign cursor_addr = st_r.cursor;
  assign mem_we = st_r.mem_we;
  assign mem_waddr = st_r.mem_waddr;
  assign mem_wdata = st_r.mem_wdata;
endmodule
`default_nettype wire

// ### core/icd_host.sv
`timescale 1ns/10ps
`default_nettype none
module icd_host
  import icd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [1:0] bus_mode,
  icd_if.host_mp bus,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp
);
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'h0,
    SEQ_SETUP = 2'h1,
    SEQ_STROBE = 2'h3,
    SEQ_HOLD = 2'h2
  } seq_type;

  typedef struct packed {
    seq_type seq;
    logic [3:0] cnt;
    logic wr_pend;
    logic [7:0] wr_ofs;
    logic [31:0] hrdata;
    logic hreadyout;
    logic [7:0] byte_q;
    logic a0_q;
    logic rd_q;
    logic [7:0] rd_data;
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] s3;
    logic [7:0] agreed;
    logic a0;
    logic wr_n;
    logic rd_n;
    logic rw;
    logic e;
    logic lds_n;
    logic [7:0] hd_o;
    logic hd_oe;
  } st_type;

  st_type st_r;
  st_type st_nxt;

  always_comb begin
    logic busy;
    logic [31:0] cmd_word;
    logic [31:0] stat_word;
    busy = (st_r.seq != SEQ_IDLE);
    cmd_word = WORD_ZERO;
    cmd_word[7:0] = st_r.byte_q;
    cmd_word[CMD_A0_BIT] = st_r.a0_q;
    cmd_word[CMD_RD_BIT] = st_r.rd_q;
    stat_word = WORD_ZERO;
    stat_word[STAT_BUSY_BIT] = busy;
    stat_word[STAT_DATA_LSB +: 8] = st_r.rd_data;
    st_nxt = st_r;
    st_nxt.s1 = bus.d;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    if (st_r.s2 == st_r.s3) st_nxt.agreed = st_r.s3;
    st_nxt.wr_pend = 1'b0;
    // address phase; zero wait states, so hready is always ours
    if (hsel && htrans == HTRANS_NONSEQ && hready) begin
      st_nxt.wr_pend = hwrite;
      st_nxt.wr_ofs = haddr[7:0];
      if (!hwrite)
        st_nxt.hrdata = (haddr[7:0] == HOST_CMD_OFS) ? cmd_word :
                        (haddr[7:0] == HOST_STAT_OFS) ? stat_word : WORD_ZERO;
    end
    unique case (st_r.seq)
      SEQ_IDLE: begin
        // a new cycle only when idle; later writes are dropped
        if (st_r.wr_pend && st_r.wr_ofs == HOST_CMD_OFS) begin
          st_nxt.byte_q = hwdata[7:0];
          st_nxt.a0_q = hwdata[CMD_A0_BIT];
          st_nxt.rd_q = hwdata[CMD_RD_BIT];
          // R12 R13 R14 a0, rw and data set up before strobe
          st_nxt.a0 = hwdata[CMD_A0_BIT];
          st_nxt.rw = hwdata[CMD_RD_BIT];
          st_nxt.hd_o = hwdata[7:0];
          st_nxt.hd_oe = !hwdata[CMD_RD_BIT];
          st_nxt.cnt = 4'(SETUP_CYC - 1);
          st_nxt.seq = SEQ_SETUP;
        end
      end
      SEQ_SETUP: begin
        st_nxt.cnt = st_r.cnt - 4'h1;
        if (st_r.cnt == 4'h0) begin
          // R12 generic uses separate strobes
          if (bus_mode == BUS_GENERIC) begin
            st_nxt.rd_n = !st_r.rd_q;
            st_nxt.wr_n = st_r.rd_q;
          end
          // R13 6800 enable high
          if (bus_mode == BUS_M6800) st_nxt.e = 1'b1;
          // R14 68000 data strobe low
          if (bus_mode == BUS_M68K) st_nxt.lds_n = 1'b0;
          st_nxt.cnt = 4'(STROBE_CYC - 1);
          st_nxt.seq = SEQ_STROBE;
        end
      end
      SEQ_STROBE: begin
        st_nxt.cnt = st_r.cnt - 4'h1;
        if (st_r.cnt == 4'h0) begin
          // strobe long enough for device sync plus ours
          if (st_r.rd_q) st_nxt.rd_data = st_r.agreed;
          st_nxt.rd_n = 1'b1;
          st_nxt.wr_n = 1'b1;
          st_nxt.e = 1'b0;
          st_nxt.lds_n = 1'b1;
          st_nxt.cnt = 4'(HOLD_CYC - 1);
          st_nxt.seq = SEQ_HOLD;
        end
      end
      SEQ_HOLD: begin
        st_nxt.cnt = st_r.cnt - 4'h1;
        if (st_r.cnt == 4'h0) begin
          st_nxt.hd_oe = 1'b0;
          st_nxt.seq = SEQ_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r <= '0;
      st_r.hreadyout <= 1'b1;
      st_r.wr_n <= 1'b1;
      st_r.rd_n <= 1'b1;
      st_r.rw <= 1'b1;
      st_r.lds_n <= 1'b1;
      st_r.seq <= SEQ_IDLE;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign hreadyout = st_r.hreadyout;
  assign hrdata = st_r.hrdata;
  assign hresp = 1'b0;
  assign bus.a0 = st_r.a0;
  assign bus.wr_n = st_r.wr_n;
  assign bus.rd_n = st_r.rd_n;
  assign bus.rw = st_r.rw;
  assign bus.e = st_r.e;
  assign bus.lds_n = st_r.lds_n;
  assign bus.hd_o = st_r.hd_o;
  assign bus.hd_oe = st_r.hd_oe;
endmodule
`default_nettype wire

// ### bench/icd_link_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module icd_link_assertions
  import icd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [1:0] bus_mode,
  input wire logic a0,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic e,
  input wire logic lds_n,
  input wire logic [7:0] hd_o,
  input wire logic hd_oe,
  input wire logic dd_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // strobe held twelve cycles, counted with the first low sample
  sequence s_low12(s);
    (!s)[*8] ##1 (!s)[*4];
  endsequence
  sequence s_idle8;
    (rd_n && !e && lds_n)[*8];
  endsequence
  a_wr_width: assert property ($fell(wr_n) |-> s_low12(wr_n) ##1 wr_n)
    else $error("write strobe width wrong");
  a_rd_width: assert property ($fell(rd_n) |-> s_low12(rd_n) ##1 rd_n)
    else $error("read strobe width wrong");
  a_e_width: assert property ($rose(e) |-> s_low12(!e) ##1 !e)
    else $error("enable strobe width wrong");
  a_lds_width: assert property ($fell(lds_n) |-> s_low12(lds_n) ##1 lds_n)
    else $error("data strobe width wrong");
  a_wr_setup: assert property ($fell(wr_n) |-> hd_oe && $past(hd_oe, 3))
    else $error("write data not set up before strobe");
  a_wr_hold: assert property ($rose(wr_n) |-> hd_oe[*3])
    else $error("write data released too early");
  a_pins_steady: assert property (!wr_n && !$past(wr_n) |-> $stable(hd_o) && $stable(a0))
    else $error("pins changed inside strobe");
  a_one_driver: assert property (!(hd_oe && dd_oe))
    else $error("both ends drive data");
  a_read_answer: assert property ($fell(rd_n) && bus_mode == BUS_GENERIC |-> ##[1:8] dd_oe)
    else $error("device did not answer read");
  a_dev_release: assert property (s_idle8 |-> !dd_oe)
    else $error("device drives outside read");
  a_mode_quiet: assert property (bus_mode == BUS_GENERIC |-> !e && lds_n)
    else $error("foreign strobe in generic mode");
endmodule
`default_nettype wire

// ### bench/tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin error_cnt++; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end
module tb;
  import icd_pkg::*;
  logic sys_clk, rst, ce, hsel, hwrite, hreadyout, hresp;
  logic display_on, standby, mem_we;
  logic [1:0] bus_mode, htrans, cursor_dir;
  logic [2:0] hsize, bpp;
  logic [31:0] haddr, hwdata, hrdata, rd, x;
  logic [7:0] mem_rdata, cfg_q, mem_wdata;
  logic [5:0] cfg_sel;
  logic [15:0] cursor_addr, mem_waddr, cur;
  int error_cnt, compares, kind, base, cnt, pos, stby, disp, dir;
  int mreg [33];
  logic [23:0] wq [$];
  logic [7:0] tc [18] = '{8'h53, 8'h59, 8'h58, 8'h44, 8'h5d, 8'h4c, 8'h4d,
    8'h4e, 8'h4f, 8'h5b, 8'h5c, 8'h5a, 8'h46, 8'h42, 8'h43, 8'h47, 8'h41, 8'h42};
  int tn [18] = '{0, 1, 2, 11, 2, 0, 0, 0, 0, 1, 2, 1, 2, 3, 0, 0, 2, 1};
  int tr [18] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 2, 3, 0, 0};
  icd_if bus();
  icd_host icd_host_i(.sys_clk(sys_clk), .rst(rst), .ce(ce),
    .bus_mode(bus_mode), .bus(bus), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));
  icd_device icd_device_i(.sys_clk(sys_clk), .rst(rst), .ce(ce),
    .bus_mode(bus_mode), .bus(bus), .mem_rdata(mem_rdata), .cfg_sel(cfg_sel),
    .cfg_q(cfg_q), .bpp(bpp), .display_on(display_on), .standby(standby),
    .cursor_dir(cursor_dir), .cursor_addr(cursor_addr), .mem_we(mem_we),
    .mem_waddr(mem_waddr), .mem_wdata(mem_wdata));
  icd_link_assertions chk_i(.sys_clk(sys_clk), .rst(rst), .bus_mode(bus_mode),
    .a0(bus.a0), .wr_n(bus.wr_n), .rd_n(bus.rd_n), .e(bus.e),
    .lds_n(bus.lds_n), .hd_o(bus.hd_o), .hd_oe(bus.hd_oe), .dd_oe(bus.dd_oe));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // memory contents follow the address so stale reads show up
  always @(posedge sys_clk) begin
    mem_rdata <= cursor_addr[7:0] ^ cursor_addr[15:8] ^ 8'h5a;
    if (mem_we === 1'b1) wq.push_back({mem_waddr, mem_wdata});
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge sys_clk);
    hsel <= 1'b1; haddr <= a; htrans <= HTRANS_NONSEQ; hwrite <= w;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic xfer(input logic [9:0] w);
    ahb(1'b1, 32'h0000_0000, {22'h0, w});
    do ahb(1'b0, 32'h0000_0004, 32'h0000_0000); while (rd[0] !== 1'b0);
  endtask
  task automatic cmd(input logic [7:0] c);
    kind = 0; cnt = 0; pos = 0; base = 0;
    if (c == 8'h40) begin cnt = 8; stby = 0; end
    else if (c == 8'h53) stby = 1;
    else if (c == 8'h58 || c == 8'h59) begin
      base = 10; cnt = 1; disp = c[0];
      if (c[0]) stby = 0;
    end
    else if (c == 8'h44) begin base = 11; cnt = 10; end
    else if (c == 8'h5d) begin base = 21; cnt = 2; end
    else if (c[7:2] == 6'h13) begin dir = c[1:0]; mreg[23] = dir; end
    else if (c == 8'h5b) begin base = 24; cnt = 1; end
    else if (c == 8'h5c) begin base = 25; cnt = 2; end
    else if (c == 8'h5a) begin base = 27; cnt = 1; end
    else if (c == 8'h46) begin base = 28; cnt = 2; kind = 1; end
    else if (c == 8'h47) kind = 2;
    else if (c == 8'h60) begin base = 32; cnt = 1; end
    else if (c == 8'h42) kind = 3;
    else if (c == 8'h43) kind = 4;
    xfer({2'b01, c});
  endtask
  task automatic par(input logic [7:0] p);
    int i;
    int m;
    logic [23:0] got;
    xfer({2'b00, p});
    i = base + pos;
    m = i == 0 ? 'h2d : i == 1 ? 'h8f : i == 2 ? 'h0f : i == 27 ? 'h07 :
      i == 32 ? 'h03 : 'hff;
    if (kind == 3) begin
      // pop once; the macro names its first value twice
      got = wq.size() == 1 ? wq.pop_front() : 24'hx;
      `CHK(got, {cur, p})
      cur++;
    end else if (pos < cnt) begin
      mreg[i] = p & m;
      if (kind == 1) cur[pos*8+:8] = p;
      pos++;
    end
  endtask
  task automatic prd();
    logic [7:0] ev;
    xfer({2'b11, 8'h00});
    ev = 8'h00;
    if (kind == 2) ev = pos == 0 ? cur[7:0] : pos == 1 ? cur[15:8] : 8'h00;
    if (kind == 4) begin
      ev = cur[7:0] ^ cur[15:8] ^ 8'h5a;
      cur++;
    end
    pos++;
    `CHK(rd[15:8], ev)
  endtask
  task automatic chk_all();
    for (int i = 0; i < 33; i++) begin
      if (!(i inside {8, 9, 28, 29, 30, 31})) begin
        cfg_sel <= 6'(i);
        repeat (3) @(posedge sys_clk);
        `CHK(cfg_q, 8'(mreg[i]))
      end
    end
    `CHK(bpp, 3'(mreg[32] == 3 ? 0 : 1 << mreg[32]))
    `CHK(standby, 1'(stby))
    `CHK(display_on, 1'(disp))
    `CHK(cursor_dir, 2'(dir))
    `CHK(cursor_addr, cur)
  endtask
  task automatic reset(input int md);
    @(posedge sys_clk);
    rst <= 1'b1;
    bus_mode <= 2'(md);
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    foreach (mreg[i]) mreg[i] = 0;
    stby = 0; disp = 0; dir = 0; cur = 16'h0000; kind = 0; cnt = 0;
  endtask
  task report_and_stop();
    $display("mismatches %0d comparisons %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    // about five times the expected run, well under the cycle budget
    repeat (60000) @(posedge sys_clk);
    error_cnt++;
    report_and_stop();
  end
  initial begin
    rst = 1'b1; ce = 1'b1; bus_mode = 2'h0; hsel = 1'b0; haddr = '0;
    htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2; hwdata = '0; cfg_sel = '0;
    mem_rdata = '0; x = 32'h0000_0011; error_cnt = 0; compares = 0;
    for (int md = 0; md < 3; md++) begin
      reset(md);
      chk_all();
      cmd(8'h40);
      // char width 7h in second byte, pan cleared next
      for (int i = 0; i < 9; i++) begin
        x = xs(x);
        par(i == 1 ? {x[7], 7'h07} : x[7:0]);
      end
      cmd(8'h5a);
      par(8'h00);
      chk_all();
      for (int i = 0; i < 4; i++) begin
        cmd(8'h60);
        par(8'hfc | 8'(i));
        chk_all();
      end
      for (int j = 0; j < 18; j++) begin
        cmd(tc[j]);
        for (int k = 0; k < tn[j]; k++) begin
          x = xs(x);
          par(x[7:0]);
        end
        repeat (tr[j]) prd();
        chk_all();
      end
      // second command while busy is dropped
      ahb(1'b1, 32'h0000_0000, 32'h0000_0153);
      ahb(1'b1, 32'h0000_0000, 32'h0000_0159);
      stby = 1; kind = 0; cnt = 0;
      do ahb(1'b0, 32'h0000_0004, 32'h0000_0000); while (rd[0] !== 1'b0);
      ahb(1'b0, 32'h0000_0000, 32'h0000_0000);
      `CHK(rd[9:0], 10'h153)
      ahb(1'b0, 32'h0000_0008, 32'h0000_0000);
      `CHK(rd, WORD_ZERO)
      chk_all();
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
